// ### firs_pkg.sv
package firs_pkg;
    // request and response frame layout
    localparam logic [7:0] CMD_CODE       = 8'h14;
    localparam int         FRAME_LEN      = 6;
    localparam logic [2:0] IDX_CMD        = 3'h0;
    localparam logic [2:0] IDX_OPT        = 3'h1;
    localparam logic [2:0] IDX_ADDR_MS    = 3'h2;
    localparam logic [2:0] IDX_ADDR_LAST  = 3'h5;
    localparam int         MODE_LSB       = 0;
    localparam int         MODE_W         = 2;
    localparam int         ADDR_W         = 24;

    // operation modes
    localparam logic [1:0] MODE_AUTH      = 2'h0;
    localparam logic [1:0] MODE_PROGRAM   = 2'h1;
    localparam logic [1:0] MODE_VERIFY    = 2'h2;

    // status byte
    localparam logic [7:0] STATUS_OK        = 8'h00;
    localparam logic [7:0] STATUS_PROTECTED = 8'hff;
    localparam int         AUTH_CODE_W      = 7;
    localparam int         PROG_CODE_W      = 6;
    localparam logic [1:0] PROG_ERR_PREFIX  = 2'h2;
    localparam logic       AUTH_ERR_PREFIX  = 1'b0;

    // programming fault codes
    localparam logic [5:0] PROG_NONE         = 6'h00;
    localparam logic [5:0] PROG_FABRIC_FAIL  = 6'h01;
    localparam logic [5:0] PROG_SECURITY     = 6'h02;
    localparam logic [5:0] PROG_NVM_PROGRAM  = 6'h04;
    localparam logic [5:0] PROG_NVM_VERIFY   = 6'h05;

    // authentication fault codes
    localparam logic [6:0] AUTH_NONE         = 7'h00;
    localparam logic [6:0] AUTH_CORRUPT      = 7'h01;
    localparam logic [6:0] AUTH_BACKLEVEL    = 7'h05;
    localparam logic [6:0] AUTH_DEVICE_ID    = 7'h0a;
    localparam logic [6:0] AUTH_OUTDATED     = 7'h0b;
    localparam logic [6:0] AUTH_NO_VERIFY    = 7'h0c;

    // flash port select lines
    localparam int         SS_W           = 8;
    localparam logic [7:0] SS_HELD_MASK   = 8'hf0;
    localparam logic [7:0] SS_IDLE        = 8'hff;

    typedef enum {
        ST_IDLE,
        ST_FREEZE_ENTER,
        ST_START,
        ST_RUN,
        ST_FREEZE_EXIT,
        ST_RESP_CMD,
        ST_RESP_STATUS,
        ST_POR
    } firs_state_t;
endpackage : firs_pkg

// ### firs_frame_rx.sv
module firs_frame_rx (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // request byte stream
    input  wire logic                           rx_valid,
    input  wire logic [7:0]                     rx_data,
    output logic                                rx_ready,
    // assembled frame
    output logic                                frame_valid,
    output logic [7:0]                          frame_cmd,
    output logic [7:0]                          frame_opt,
    output logic [firs_pkg::ADDR_W-1:0]         frame_addr,
    input  wire logic                           frame_taken
);
    logic [2:0]                  count;
    logic [2:0]                  next_count;
    logic                        full;
    logic                        next_full;
    logic [7:0]                  next_cmd;
    logic [7:0]                  next_opt;
    logic [firs_pkg::ADDR_W-1:0] next_addr;

    // a held frame stalls the stream until the idle service takes it
    assign rx_ready    = !full;
    assign frame_valid = full;

    always_comb begin
        next_count = count;
        next_full  = full;
        next_cmd   = frame_cmd;
        next_opt   = frame_opt;
        next_addr  = frame_addr;
        if (full && frame_taken) begin
            next_full = 1'b0;
        end
        if (rx_valid && !full) begin
            case (count)
                firs_pkg::IDX_CMD: begin
                    next_cmd = rx_data;
                end
                firs_pkg::IDX_OPT: begin
                    next_opt = rx_data;
                end
                firs_pkg::IDX_ADDR_MS: begin
                    // most significant address byte is dropped
                end
                default: begin
                    next_addr = {frame_addr[firs_pkg::ADDR_W-9:0], rx_data};
                end
            endcase
            if (count == firs_pkg::IDX_ADDR_LAST) begin
                next_count = 3'h0;
                next_full  = 1'b1;
            end else begin
                next_count = count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count      <= 3'h0;
            full       <= 1'b0;
            frame_cmd  <= 8'h00;
            frame_opt  <= 8'h00;
            frame_addr <= '0;
        end else begin
            count      <= next_count;
            full       <= next_full;
            frame_cmd  <= next_cmd;
            frame_opt  <= next_opt;
            frame_addr <= next_addr;
        end
    end
endmodule : firs_frame_rx

// ### firs_flash_port.sv
module firs_flash_port (
    // ownership
    input  wire logic                       owned,
    input  wire logic                       program_hold,
    input  wire logic                       small_variant,
    // requester side port
    input  wire logic                       user_sck,
    input  wire logic                       user_mosi,
    input  wire logic [firs_pkg::SS_W-1:0]  user_ss,
    output logic                            user_miso,
    // controller side port
    input  wire logic                       ctrl_sck,
    input  wire logic                       ctrl_mosi,
    input  wire logic [firs_pkg::SS_W-1:0]  ctrl_ss,
    output logic                            ctrl_miso,
    // pins
    output logic                            flash_sck_o,
    output logic                            flash_sck_oe,
    output logic                            flash_mosi_o,
    output logic                            flash_mosi_oe,
    output logic [firs_pkg::SS_W-1:0]       flash_ss_o,
    output logic [firs_pkg::SS_W-1:0]       flash_ss_oe,
    input  wire logic                       flash_miso_i
);
    always_comb begin
        flash_sck_o   = user_sck;
        flash_sck_oe  = 1'b1;
        flash_mosi_o  = user_mosi;
        flash_mosi_oe = 1'b1;
        flash_ss_o    = user_ss;
        flash_ss_oe   = {firs_pkg::SS_W{1'b1}};
        user_miso     = flash_miso_i;
        ctrl_miso     = 1'b0;
        if (owned) begin
            // requester is cut off entirely while the service owns the port
            user_miso     = 1'b0;
            ctrl_miso     = flash_miso_i;
            flash_sck_o   = ctrl_sck;
            flash_mosi_o  = ctrl_mosi;
            flash_ss_o    = ctrl_ss;
            if (program_hold && !small_variant) begin
                // upper selects held high, rest released to the weak pull-ups
                flash_sck_oe  = 1'b0;
                flash_mosi_oe = 1'b0;
                flash_ss_o    = firs_pkg::SS_HELD_MASK;
                flash_ss_oe   = firs_pkg::SS_HELD_MASK;
            end
        end
    end
endmodule : firs_flash_port

// ### firs_service.sv
// Operation
// - request: code, options, four address bytes
// - options low bits select the mode
// - answer code echo then status byte
// - status zero, 255 protected, bit-7 error classes
// - programming fault code values
// - controller owns flash port during service
// - program: four selects high, others released (not on the small variant, which drives all pins)
// - authenticate leaves fabric and subsystem running
// - verify freezes whole operation, then wakes
// - verify freeze messages precede the response (the exit message comes in the same cycle as the echo byte)
// - program freezes and messages before starting (the freeze and the entry message come in the same cycle as the engine start)
// - program success triggers power-on reset
// - fabric frozen throughout programming
// - program fetches and authenticates image on fly
// - authentication fault code values
module firs_service (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // request byte stream
    input  wire logic                           rx_valid,
    input  wire logic [7:0]                     rx_data,
    output logic                                rx_ready,
    // response byte stream
    output logic                                tx_valid,
    output logic [7:0]                          tx_data,
    input  wire logic                           tx_ready,
    // configuration
    input  wire logic                           service_protected,
    input  wire logic                           small_variant,
    // image engine
    output logic                                eng_start,
    output logic [firs_pkg::MODE_W-1:0]         eng_mode,
    output logic [firs_pkg::ADDR_W-1:0]         image_base_address,
    input  wire logic                           eng_done,
    input  wire logic [firs_pkg::AUTH_CODE_W-1:0] auth_fault_code,
    input  wire logic [firs_pkg::PROG_CODE_W-1:0] program_fault_code,
    // device state
    output logic                                fabric_freeze,
    output logic                                freeze_entry_msg,
    output logic                                freeze_exit_msg,
    output logic                                por_request,
    output logic                                service_busy,
    // requester side flash port
    input  wire logic                           user_sck,
    input  wire logic                           user_mosi,
    input  wire logic [firs_pkg::SS_W-1:0]      user_ss,
    output logic                                user_miso,
    // engine side flash port
    input  wire logic                           ctrl_sck,
    input  wire logic                           ctrl_mosi,
    input  wire logic [firs_pkg::SS_W-1:0]      ctrl_ss,
    output logic                                ctrl_miso,
    // flash pins
    output logic                                flash_sck_o,
    output logic                                flash_sck_oe,
    output logic                                flash_mosi_o,
    output logic                                flash_mosi_oe,
    output logic [firs_pkg::SS_W-1:0]           flash_ss_o,
    output logic [firs_pkg::SS_W-1:0]           flash_ss_oe,
    input  wire logic                           flash_miso_i
);
    firs_pkg::firs_state_t state;
    firs_pkg::firs_state_t next_state;

    logic                           frame_valid;
    logic [7:0]                     frame_cmd;
    logic [7:0]                     frame_opt;
    logic [firs_pkg::ADDR_W-1:0]    frame_addr;
    logic                           frame_taken;

    logic [firs_pkg::MODE_W-1:0]    mode;
    logic [firs_pkg::MODE_W-1:0]    next_mode;
    logic [firs_pkg::ADDR_W-1:0]    next_address;
    logic [7:0]                     status;
    logic [7:0]                     next_status;
    logic                           freeze;
    logic                           next_freeze;
    logic                           owned;
    logic                           next_owned;
    logic                           entry_msg;
    logic                           next_entry_msg;
    logic                           exit_msg;
    logic                           next_exit_msg;
    logic                           por;
    logic                           next_por;
    logic [firs_pkg::MODE_W-1:0]    req_mode;
    logic [7:0]                     result;

    firs_frame_rx u_frame_rx (
        .clk         (clk),
        .nrst        (nrst),
        .rx_valid    (rx_valid),
        .rx_data     (rx_data),
        .rx_ready    (rx_ready),
        .frame_valid (frame_valid),
        .frame_cmd   (frame_cmd),
        .frame_opt   (frame_opt),
        .frame_addr  (frame_addr),
        .frame_taken (frame_taken)
    );

    firs_flash_port u_flash_port (
        .owned         (owned),
        .program_hold  (freeze && (mode == firs_pkg::MODE_PROGRAM)),
        .small_variant (small_variant),
        .user_sck      (user_sck),
        .user_mosi     (user_mosi),
        .user_ss       (user_ss),
        .user_miso     (user_miso),
        .ctrl_sck      (ctrl_sck),
        .ctrl_mosi     (ctrl_mosi),
        .ctrl_ss       (ctrl_ss),
        .ctrl_miso     (ctrl_miso),
        .flash_sck_o   (flash_sck_o),
        .flash_sck_oe  (flash_sck_oe),
        .flash_mosi_o  (flash_mosi_o),
        .flash_mosi_oe (flash_mosi_oe),
        .flash_ss_o    (flash_ss_o),
        .flash_ss_oe   (flash_ss_oe),
        .flash_miso_i  (flash_miso_i)
    );

    assign req_mode = frame_opt[firs_pkg::MODE_LSB +: firs_pkg::MODE_W];

    // authentication faults take precedence: a bad image never reaches programming
    always_comb begin
        if (auth_fault_code != firs_pkg::AUTH_NONE) begin
            result = {firs_pkg::AUTH_ERR_PREFIX, auth_fault_code};
        end else if (program_fault_code != firs_pkg::PROG_NONE) begin
            result = {firs_pkg::PROG_ERR_PREFIX, program_fault_code};
        end else begin
            result = firs_pkg::STATUS_OK;
        end
    end

    always_comb begin
        next_state     = state;
        next_mode      = mode;
        next_address   = image_base_address;
        next_status    = status;
        next_freeze    = freeze;
        next_owned     = owned;
        next_entry_msg = 1'b0;
        next_exit_msg  = 1'b0;
        next_por       = 1'b0;
        frame_taken    = 1'b0;
        case (state)
            firs_pkg::ST_IDLE: begin
                if (frame_valid) begin
                    frame_taken = 1'b1;
                    // frames with a foreign command code are dropped silently
                    if (frame_cmd == firs_pkg::CMD_CODE) begin
                        next_mode    = req_mode;
                        next_address = frame_addr;
                        if (service_protected) begin
                            next_status = firs_pkg::STATUS_PROTECTED;
                            next_state  = firs_pkg::ST_RESP_CMD;
                        end else if (req_mode == firs_pkg::MODE_AUTH) begin
                            // no freeze: fabric and subsystem keep running
                            next_owned = 1'b1;
                            next_state = firs_pkg::ST_START;
                        end else if (req_mode == firs_pkg::MODE_PROGRAM ||
                                     req_mode == firs_pkg::MODE_VERIFY) begin
                            next_owned = 1'b1;
                            next_state = firs_pkg::ST_FREEZE_ENTER;
                        end else begin
                            next_status = {firs_pkg::PROG_ERR_PREFIX, firs_pkg::PROG_SECURITY};
                            next_state  = firs_pkg::ST_RESP_CMD;
                        end
                    end
                end
            end
            firs_pkg::ST_FREEZE_ENTER: begin
                next_freeze    = 1'b1;
                next_entry_msg = 1'b1;
                next_state     = firs_pkg::ST_START;
            end
            firs_pkg::ST_START: begin
                // engine streams and checks the image as it goes
                next_state = firs_pkg::ST_RUN;
            end
            firs_pkg::ST_RUN: begin
                if (eng_done) begin
                    next_status = result;
                    next_owned  = 1'b0;
                    if (freeze) begin
                        next_state = firs_pkg::ST_FREEZE_EXIT;
                    end else begin
                        next_state = firs_pkg::ST_RESP_CMD;
                    end
                end
            end
            firs_pkg::ST_FREEZE_EXIT: begin
                // woken as the answer opens, so the exit message comes in the same cycle as the echo byte
                next_freeze   = 1'b0;
                next_exit_msg = 1'b1;
                next_state    = firs_pkg::ST_RESP_CMD;
            end
            firs_pkg::ST_RESP_CMD: begin
                if (tx_ready) begin
                    next_state = firs_pkg::ST_RESP_STATUS;
                end
            end
            firs_pkg::ST_RESP_STATUS: begin
                if (tx_ready) begin
                    if (mode == firs_pkg::MODE_PROGRAM && status == firs_pkg::STATUS_OK &&
                        !service_protected) begin
                        next_state = firs_pkg::ST_POR;
                    end else begin
                        next_state = firs_pkg::ST_IDLE;
                    end
                end
            end
            firs_pkg::ST_POR: begin
                next_por   = 1'b1;
                next_state = firs_pkg::ST_IDLE;
            end
            default: begin
                next_state = firs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state              <= firs_pkg::ST_IDLE;
            mode               <= firs_pkg::MODE_AUTH;
            image_base_address <= '0;
            status             <= firs_pkg::STATUS_OK;
            freeze             <= 1'b0;
            owned              <= 1'b0;
            entry_msg          <= 1'b0;
            exit_msg           <= 1'b0;
            por                <= 1'b0;
        end else begin
            state              <= next_state;
            mode               <= next_mode;
            image_base_address <= next_address;
            status             <= next_status;
            freeze             <= next_freeze;
            owned              <= next_owned;
            entry_msg          <= next_entry_msg;
            exit_msg           <= next_exit_msg;
            por                <= next_por;
        end
    end

    // response bytes: code echo first, then status
    assign tx_valid = (state == firs_pkg::ST_RESP_CMD) || (state == firs_pkg::ST_RESP_STATUS);
    always_comb begin
        if (state == firs_pkg::ST_RESP_STATUS) begin
            tx_data = status;
        end else if (state == firs_pkg::ST_RESP_CMD) begin
            tx_data = firs_pkg::CMD_CODE;
        end else begin
            tx_data = 8'h00;
        end
    end

    assign eng_start        = (state == firs_pkg::ST_START);
    assign eng_mode         = mode;
    assign fabric_freeze    = freeze;
    assign freeze_entry_msg = entry_msg;
    assign freeze_exit_msg  = exit_msg;
    assign por_request      = por;
    assign service_busy     = owned;
endmodule : firs_service

// ### firs_service_assertions.sv
module firs_service_assertions (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        nrst,
    // response and configuration
    input wire logic                        tx_valid,
    input wire logic [7:0]                  tx_data,
    input wire logic                        small_variant,
    // service state
    input wire logic                        eng_start,
    input wire logic [firs_pkg::MODE_W-1:0] eng_mode,
    input wire logic                        fabric_freeze,
    input wire logic                        freeze_entry_msg,
    input wire logic                        freeze_exit_msg,
    input wire logic                        por_request,
    input wire logic                        service_busy,
    // flash port
    input wire logic [firs_pkg::SS_W-1:0]   ctrl_ss,
    input wire logic                        user_miso,
    input wire logic                        flash_sck_oe,
    input wire logic [firs_pkg::SS_W-1:0]   flash_ss_o,
    input wire logic [firs_pkg::SS_W-1:0]   flash_ss_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_echo;
        tx_valid && tx_data == firs_pkg::CMD_CODE;
    endsequence
    sequence s_exit;
        !fabric_freeze && freeze_exit_msg;
    endsequence
    logic held;
    assign held = fabric_freeze && eng_mode == firs_pkg::MODE_PROGRAM && !small_variant;

    echo_first_a: assert property ($rose(tx_valid) |-> s_echo)
        else $error("response does not open with the command echo");
    freeze_entry_a: assert property ($rose(fabric_freeze) |-> freeze_entry_msg && eng_start)
        else $error("freeze entered without entry message before work");
    exit_order_a: assert property ($fell(fabric_freeze) |-> s_exit ##0 s_echo)
        else $error("freeze exit not paired with response start");
    verify_wake_a: assert property ($fell(service_busy) && fabric_freeze |=> s_exit)
        else $error("frozen device not woken after work");
    flash_owned_a: assert property (service_busy && !held |-> flash_ss_o == ctrl_ss && user_miso == 1'b0)
        else $error("flash port not owned by controller while busy");
    select_hold_a: assert property (service_busy && held |-> flash_ss_o == firs_pkg::SS_HELD_MASK
        && flash_ss_oe == firs_pkg::SS_HELD_MASK && !flash_sck_oe)
        else $error("selects not held during programming");
    auth_live_a: assert property (service_busy && eng_mode == firs_pkg::MODE_AUTH |-> !fabric_freeze)
        else $error("fabric frozen during authenticate");
    frozen_work_a: assert property (eng_start && eng_mode != firs_pkg::MODE_AUTH |-> fabric_freeze)
        else $error("engine started without freeze");
    por_after_ok_a: assert property (por_request |-> $past(tx_data, 2) == firs_pkg::STATUS_OK && !service_busy)
        else $error("reset request without success status");
endmodule : firs_service_assertions

bind firs_service firs_service_assertions u_chk (.clk, .nrst, .tx_valid, .tx_data, .small_variant, .eng_start,
    .eng_mode, .fabric_freeze, .freeze_entry_msg, .freeze_exit_msg, .por_request, .service_busy, .ctrl_ss,
    .user_miso, .flash_sck_oe, .flash_ss_o, .flash_ss_oe);

// ### firs_engine_model.sv
module firs_engine_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       eng_start,
    input  wire logic [7:0] dly,
    input  wire logic [6:0] acode,
    input  wire logic [5:0] pcode,
    output logic            eng_done = 1'b0,
    output logic [6:0]      auth_fault_code = 7'h00,
    output logic [5:0]      program_fault_code = 6'h00,
    output logic            ctrl_sck = 1'b0,
    output logic            ctrl_mosi = 1'b0,
    output logic [7:0]      ctrl_ss = 8'hff
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // codes change every cycle outside the done cycle so stale values never look valid
    always @(negedge clk) begin
        eng_done <= 1'b0;
        auth_fault_code <= 7'($urandom);
        program_fault_code <= 6'($urandom);
        {ctrl_sck, ctrl_mosi, ctrl_ss} <= 10'($urandom);
        if (!nrst) cnt = 0;
        else if (eng_start) cnt = dly;
        else if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                eng_done <= 1'b1;
                auth_fault_code <= acode;
                program_fault_code <= pcode;
            end
        end
    end
endmodule : firs_engine_model

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] C = firs_pkg::CMD_CODE;
    logic clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, service_protected = 1'b0;
    logic small_variant = 1'b0, user_sck = 1'b0, user_mosi = 1'b0, flash_miso_i = 1'b0, in_call = 1'b0;
    logic [7:0] rx_data = 8'h00, user_ss = 8'hff, dly = 8'h01, tx_data, ctrl_ss, flash_ss_o, flash_ss_oe;
    logic [6:0] acode = 7'h00, auth_fault_code;
    logic [5:0] pcode = 6'h00, program_fault_code;
    logic rx_ready, tx_valid, eng_start, eng_done, fabric_freeze, freeze_entry_msg, freeze_exit_msg;
    logic por_request, service_busy, user_miso, ctrl_sck, ctrl_mosi, ctrl_miso;
    logic flash_sck_o, flash_sck_oe, flash_mosi_o, flash_mosi_oe;
    logic [1:0] eng_mode, exp_mode;
    logic [23:0] image_base_address, exp_addr;
    logic [7:0] q[$];
    int fails = 0, n_compared = 0, n_por = 0, exp_por = 0;

    firs_service DUT (.clk, .nrst, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
        .service_protected, .small_variant, .eng_start, .eng_mode, .image_base_address, .eng_done,
        .auth_fault_code, .program_fault_code, .fabric_freeze, .freeze_entry_msg, .freeze_exit_msg,
        .por_request, .service_busy, .user_sck, .user_mosi, .user_ss, .user_miso, .ctrl_sck, .ctrl_mosi,
        .ctrl_ss, .ctrl_miso, .flash_sck_o, .flash_sck_oe, .flash_mosi_o, .flash_mosi_oe, .flash_ss_o,
        .flash_ss_oe, .flash_miso_i);
    firs_engine_model u_eng (.clk, .nrst, .eng_start, .dly, .acode, .pcode, .eng_done, .auth_fault_code,
        .program_fault_code, .ctrl_sck, .ctrl_mosi, .ctrl_ss);

    initial forever #5 clk = ~clk;

    task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // requester idles its own flash port from request to answer
    always @(negedge clk) begin
        tx_ready = $urandom_range(3) != 0;
        flash_miso_i = 1'($urandom);
        {user_sck, user_mosi, user_ss} = in_call ? 10'h0ff : 10'($urandom);
    end

    always @(posedge clk) if (nrst) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (q.size() == 0) begin
                fails++;
                $display("ERROR tx_data expected none seen %h", tx_data);
            end else check("tx_data", {16'h0, tx_data}, {16'h0, q.pop_front()});
        end
        if (eng_start === 1'b1) begin
            check("image_base_address", image_base_address, exp_addr);
            check("eng_mode", {22'h0, eng_mode}, {22'h0, exp_mode});
        end
        if (por_request === 1'b1) n_por++;
    end

    task send(input logic [7:0] b);
        rx_data = b;
        rx_valid = 1'b1; // delivery port kept enabled
        while (rx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : send

    task run(input logic [7:0] cmd, input logic [1:0] m, input logic [6:0] a, input logic [5:0] p,
             input logic pr, input logic sm);
        logic [31:0] addr;
        logic [7:0] st;
        int i;
        addr = $urandom;
        acode = a;
        pcode = p;
        service_protected = pr;
        small_variant = sm;
        dly = 8'($urandom_range(9, 1));
        exp_addr = addr[23:0];
        exp_mode = m;
        st = pr ? firs_pkg::STATUS_PROTECTED : m == 2'h3 ? 8'h82 : a != 0 ? {1'b0, a} : p != 0 ? {2'h2, p} : 8'h00;
        if (cmd == C) begin
            q.push_back(C);
            q.push_back(st);
            if (st == 8'h00 && m == firs_pkg::MODE_PROGRAM) exp_por++;
        end
        in_call = 1'b1;
        send(cmd);
        send({6'($urandom), m});
        for (i = 3; i >= 0; i--) send(addr[8*i +: 8]);
        rx_valid = 1'b0;
        i = 0;
        while ((q.size() != 0 || service_busy !== 1'b0) && i < 300) begin
            @(negedge clk);
            i++;
        end
        in_call = 1'b0;
        check("response wait", {23'h0, i >= 300}, 24'h0);
        repeat (4) @(negedge clk);
        check("por count", 24'(n_por), 24'(exp_por));
        if (st == 8'h00 && m == firs_pkg::MODE_PROGRAM && cmd == C) begin
            // system reset on top of the controller's own
            nrst = 1'b0;
            repeat (2) @(negedge clk);
            nrst = 1'b1;
            check("rx_ready after reset", {23'h0, rx_ready}, 24'h1);
        end
        $display("test done cmd %h mode %0d status %h", cmd, m, st);
    endtask : run

    initial begin
        void'($urandom(32'h0d012114));
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        run(C, 2'h0, 7'h00, 6'h00, 1'b0, 1'b0);
        run(C, 2'h0, 7'h05, 6'h00, 1'b0, 1'b0);
        run(8'h15, 2'h1, 7'h00, 6'h00, 1'b0, 1'b0);
        run(C, 2'h2, 7'h00, 6'h00, 1'b0, 1'b0); // digest check taken as done before verify
        run(C, 2'h2, 7'h0c, 6'h00, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h01, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h02, 1'b0, 1'b1);
        run(C, 2'h1, 7'h00, 6'h04, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h05, 1'b0, 1'b0);
        run(C, 2'h1, 7'h0a, 6'h04, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h00, 1'b1, 1'b0);
        run(C, 2'h3, 7'h00, 6'h00, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h00, 1'b0, 1'b0);
        run(C, 2'h1, 7'h00, 6'h00, 1'b0, 1'b1);
        repeat (6) run(C, 2'($urandom_range(2)), $urandom_range(1) ? 7'($urandom_range(12, 1)) : 7'h00,
            6'h00, 1'b0, 1'($urandom));
        results();
    end

    initial begin
        #100us;
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        results();
    end
endmodule : testbench
